// file: bench/psi5sw_ecu.sv
// Control-unit model: sync pulses, decoded short commands, frame capture.
// Assumes the framer shares clk; commands arrive already decoded.
`timescale 1ns/1ps
module psi5sw_ecu (
  input  wire logic       clk,
  input  wire logic       frame_start,
  input  wire logic [9:0] frame_data,
  output logic            sync_pin,
  output logic            cmd_valid,
  output logic            cmd_err,
  output logic [2:0]      cmd_sensor_address_field,
  output logic [2:0]      cmd_function_code_field,
  output logic [9:0]      cmd_error_number
);
  logic [9:0] fq[$];
  int         dq[$];
  int         cyc = 0;
  logic       sync_q = 1'b0;

  initial begin
    {sync_pin, cmd_valid, cmd_err} = 3'h0;
    {cmd_sensor_address_field, cmd_function_code_field} = 6'h3f;
    cmd_error_number = 10'h3ff;
  end

  // Frames and their delay from the sync rising edge
  always @(posedge clk) begin
    sync_q <= sync_pin;
    cyc <= (sync_pin && !sync_q) ? 1 : cyc + 1;
    if (frame_start === 1'b1) begin
      fq.push_back(frame_data);
      dq.push_back(cyc);
    end
  end

  task automatic sync_pulse();
    sync_pin <= 1'b1;
    repeat (4) @(posedge clk);
    sync_pin <= 1'b0;
  endtask

  // Short command, one cycle; fields scrambled when not qualified
  task automatic send_cmd(input logic [2:0] a, input logic [2:0] f,
                          input logic e, input logic [9:0] n);
    cmd_valid <= 1'b1;
    cmd_sensor_address_field <= a;
    cmd_function_code_field <= f;
    cmd_err <= e;
    cmd_error_number <= n;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_sensor_address_field <= ~a;
    cmd_function_code_field <= ~f;
    cmd_error_number <= ~n;
  endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the PSI5 split-word and daisy-chain framer.
// Assumes the control-unit model psi5sw_ecu and a 50 MHz clock.
`timescale 1ns/1ps
`include "psi5sw_params.svh"
module testbench;
  localparam logic [9:0]  DEF = 10'h1f0;
  localparam logic [25:0] S1  = 26'h0012345;
  localparam logic [25:0] S2  = 26'h0001060;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, frame_start, frame_chain_format;
  logic        bus_switch_close, sync_pulldown_en, sync_pin;
  logic        cmd_valid, cmd_err;
  logic [2:0]  cmd_sensor_address_field, cmd_function_code_field;
  logic [9:0]  cmd_error_number, frame_data;
  logic        offset_err_pin = 1'b0;
  logic        selftest_fail_pin = 1'b0;
  logic        identity_valid_flag = 1'b1;
  logic        identity_default_flag = 1'b1;
  logic        undervolt_pin = 1'b0;
  logic        temp_fail_pin = 1'b0;
  logic [25:0] sample_data = S1;
  logic        init_active = 1'b0;
  logic        init_done = 1'b0;
  logic [9:0]  init_word = 10'h000;
  int          error_cnt = 0;
  int          check_count = 0;
  int          tw = 220;

  psi5sw_top #(.BLANK_CYC(24'h000014)) i_psi5sw_top (
    .clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sync_pin,
    .offset_err_pin, .selftest_fail_pin, .identity_valid_flag,
    .identity_default_flag, .undervolt_pin, .temp_fail_pin, .sample_data,
    .init_active, .init_done, .init_word, .cmd_valid, .cmd_err,
    .cmd_sensor_address_field, .cmd_function_code_field, .cmd_error_number,
    .frame_start, .frame_data, .frame_chain_format, .bus_switch_close,
    .sync_pulldown_en);

  psi5sw_ecu i_psi5sw_ecu (
    .clk, .frame_start, .frame_data, .sync_pin, .cmd_valid, .cmd_err,
    .cmd_sensor_address_field, .cmd_function_code_field, .cmd_error_number);

  always #10 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic rst_dut();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(r, e);
  endtask

  // One sync; sample changes 42 cycles later; frames judged after
  task automatic burst(input int t, input logic [25:0] s2, input int n,
                       input logic [9:0] e0, input logic [9:0] e1);
    repeat (8) @(posedge clk);
    i_psi5sw_ecu.fq.delete();
    i_psi5sw_ecu.dq.delete();
    i_psi5sw_ecu.sync_pulse();
    repeat (42) @(posedge clk);
    sample_data <= s2;
    repeat (tw * 25 + 300) @(posedge clk);
    check(32'(i_psi5sw_ecu.fq.size()), 32'(n));
    if (n > 0) begin
      check({31'h0, 32'(i_psi5sw_ecu.dq[0] - t * 25) <= 32'h8}, 32'h1);
      check(32'(i_psi5sw_ecu.fq[0]), 32'(e0));
    end
    if (n > 1) check(32'(i_psi5sw_ecu.fq[1]), 32'(e1));
  endtask

  task automatic t_hires();
    rdc(`PSI5SW_OFF_CTRL, 32'h0);
    rdc(8'h40, 32'h0);
    wr(`PSI5SW_OFF_CTRL, 32'h2);
    wr(`PSI5SW_OFF_SLOTA, 32'ha);
    wr(`PSI5SW_OFF_SLOTB, 32'hdc);
    burst(10, S1, 2, 10'h012, 10'h1e0);
    wr(`PSI5SW_OFF_CTRL, 32'h6);
    burst(10, S2, 2, 10'h001, 10'h042);
    wr(`PSI5SW_OFF_CTRL, 32'h2);
    wr(`PSI5SW_OFF_SLOTB, 32'h64);
    burst(10, S1, 1, 10'h001, 10'h000);
    wr(`PSI5SW_OFF_SLOTB, 32'hdc);
    init_active <= 1'b1;
    init_word <= 10'h2a5;
    burst(10, S1, 2, 10'h2a5, 10'h2a5);
    init_active <= 1'b0;
  endtask

  task automatic t_faults();
    offset_err_pin <= 1'b1;
    burst(10, S1, 2, DEF, DEF);
    offset_err_pin <= 1'b0;
    undervolt_pin <= 1'b1;
    burst(10, S1, 0, 10'h000, 10'h000);
    undervolt_pin <= 1'b0;
    temp_fail_pin <= 1'b1;
    burst(10, S1, 0, 10'h000, 10'h000);
    temp_fail_pin <= 1'b0;
    burst(10, S1, 2, 10'h012, 10'h1e0);
  endtask

  task automatic t_chain();
    rst_dut();
    tw = 100;
    wr(`PSI5SW_OFF_CTRL, 32'h3);
    init_active <= 1'b1;
    init_word <= 10'h155;
    burst(80, S1, 1, 10'h155, 10'h000);
    check(32'(sync_pulldown_en), 32'h1);
    init_active <= 1'b0;
    init_done <= 1'b1;
    burst(80, S1, 0, 10'h000, 10'h000);
    i_psi5sw_ecu.send_cmd(3'h0, 3'h1, 1'b1, 10'h0a5);
    burst(80, S1, 1, 10'h1e2, 10'h000);
    burst(80, S1, 1, 10'h0a5, 10'h000);
    i_psi5sw_ecu.send_cmd(3'h0, 3'h1, 1'b0, 10'h000);
    burst(80, S1, 1, 10'h1e1, 10'h000);
    burst(80, S1, 1, 10'h001, 10'h000);
    check(32'(bus_switch_close), 32'h1);
    burst(100, S1, 0, 10'h000, 10'h000);
    i_psi5sw_ecu.send_cmd(3'h7, 3'h0, 1'b0, 10'h000);
    burst(100, S1, 1, 10'h1e1, 10'h000);
    burst(100, S1, 1, 10'h000, 10'h000);
    i_psi5sw_ecu.send_cmd(3'h0, 3'h2, 1'b0, 10'h000);
    burst(100, S1, 1, 10'h012, 10'h000);
    rdc(`PSI5SW_OFF_STAT, 32'h29);
    check(32'(frame_chain_format), 32'h1);
    check(32'(sync_pulldown_en), 32'h1);
    selftest_fail_pin <= 1'b1;
    repeat (10) @(posedge clk);
    selftest_fail_pin <= 1'b0;
    burst(100, S1, 1, DEF, 10'h000);
    burst(100, S1, 1, DEF, 10'h000);
    rst_dut();
    rdc(`PSI5SW_OFF_STAT, 32'h0);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial begin
    @(posedge clk);
    rst_dut();
    t_hires();
    t_faults();
    t_chain();
    final_report();
  end
endmodule

// file: shared/psi5sw_params.svh
// Constants for the PSI5 split-word and daisy-chain framer.
// Assumes a 50 MHz core clock and AHB-Lite word access.
`ifndef PSI5SW_PARAMS_SVH
`define PSI5SW_PARAMS_SVH
// Register byte offsets
`define PSI5SW_OFF_CTRL    8'h00
`define PSI5SW_OFF_SLOTA   8'h04
`define PSI5SW_OFF_SLOTB   8'h08
`define PSI5SW_OFF_STAT    8'h0c
`define PSI5SW_OFF_WORD    8'h10
// Control field positions and reset values
`define PSI5SW_CTRL_MODE_LSB 0
`define PSI5SW_CTRL_LAT_BIT  2
`define PSI5SW_CTRL_RST      2'h0
`define PSI5SW_SLOT_RST      10'h000
// Reply codes and fixed words
`define PSI5SW_RC_OK       10'h1e1
`define PSI5SW_RC_ERR      10'h1e2
`define PSI5SW_RUN_WORD    10'h000
`define PSI5SW_ADDR_GLOBAL 3'h7
`define PSI5SW_ADDR_NONE   3'h0
// Second-slot clip limit in counts
`define PSI5SW_CLIP_LIM    480
// Timing: slot unit is 0.5 us
`define PSI5SW_CLK_MHZ     50
`define PSI5SW_UNIT_NS     500
`define PSI5SW_UNIT_CYC    ((`PSI5SW_UNIT_NS * `PSI5SW_CLK_MHZ) / 1000)
// Frame of 13 bits at 125 kBaud
`define PSI5SW_FRAME_US    104
`define PSI5SW_FRAME_UNITS ((`PSI5SW_FRAME_US * 1000) / `PSI5SW_UNIT_NS)
`endif

// file: shared/psi5sw_pkg.sv
// Types for the PSI5 split-word and daisy-chain framer.
// Assumes psi5sw_params.svh is included by the design file.
package psi5sw_pkg;
  typedef enum logic [1:0] {
    PSI5SW_MODE_NORMAL = 2'h0,
    PSI5SW_MODE_DOUBLE = 2'h1,
    PSI5SW_MODE_HIRES  = 2'h2,
    PSI5SW_MODE_CHAIN  = 2'h3
  } psi5sw_mode_t;

  typedef enum logic [2:0] {
    PSI5SW_CH_INIT  = 3'h0,
    PSI5SW_CH_WADDR = 3'h1,
    PSI5SW_CH_REPA  = 3'h3,
    PSI5SW_CH_BLANK = 3'h2,
    PSI5SW_CH_WRUN  = 3'h6,
    PSI5SW_CH_REPR  = 3'h7,
    PSI5SW_CH_RUN   = 3'h5
  } psi5sw_chain_t;

  typedef struct packed {
    logic          sync_s1;
    logic          sync_s2;
    logic          sync_d;
    logic [5:0]    flt_s1;
    logic [5:0]    flt_s2;
    psi5sw_mode_t  mode;
    logic          lat;
    logic [9:0]    slot_a;
    logic [9:0]    slot_b;
    logic [7:0]    haddr;
    logic          dph;
    logic [31:0]   hrdata;
    logic [4:0]    pre;
    logic [10:0]   cnt;
    logic          act;
    logic [15:0]   sample;
    psi5sw_chain_t chain;
    logic [2:0]    addr;
    logic [9:0]    rep_code;
    logic [9:0]    rep_word;
    logic [1:0]    rep_cnt;
    logic [23:0]   blank;
    logic          defect;
    logic          fs;
    logic [9:0]    fdata;
  } psi5sw_state_t;
endpackage

// file: src/psi5sw_top.sv
// PSI5 split-word (16-bit) and daisy-chain framer with AHB-Lite registers.
// Assumes sample, init and command inputs are on clk; sync and fault
// inputs are pins and are synchronised here.
// Notes on behaviour
// - Hi-res mode rounds result bits 25..6, saturated to 16
// - Latency bit picks sync edge or first slot
// - Upper ten bits sent at first slot
// - Clip to 480, lower ten at second slot
// - Init data identical in both slots
// - Overlapping slots drop the second frame
// - Chain mode latency choice as other modes
// - Chain init frames use chain setup slot
// - After init, silent until address command
// - Address reply sent in setup slot
// - Blank syncs after address, then await run
// - Run reply, then data in address slot
// - Chain enables sync pulldown in init and run
// - Run broadcast answered with OK and zero, or with error code and number on cmd_err
// - Replies carry 0x1E1 or 0x1E2 codes
// - Address maps switch state and chain slot
// - All-ones address is broadcast, never assigned
// - Offset error gives defect word while present
// - Self-test or identity fault latches defect
// - Undervoltage silences all frames while present
// - Temperature fault silences all frames
`timescale 1ns/1ps
`include "psi5sw_params.svh"

module psi5sw_top #(
  parameter logic [9:0]  DEFECT_WORD   = 10'h1f0,
  parameter logic [9:0]  SETUP_SLOT    = 10'h050,
  parameter logic [9:0]  CHAIN_SLOT1   = 10'h064,
  parameter logic [9:0]  CHAIN_SLOT2   = 10'h14a,
  parameter logic [9:0]  CHAIN_SLOT3   = 10'h230,
  parameter int          BLANK_US      = 1000,
  parameter logic [23:0] BLANK_CYC     = 24'(BLANK_US * `PSI5SW_CLK_MHZ)
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sync_pin,
  input  wire logic        offset_err_pin,
  input  wire logic        selftest_fail_pin,
  input  wire logic        identity_valid_flag,
  input  wire logic        identity_default_flag,
  input  wire logic        undervolt_pin,
  input  wire logic        temp_fail_pin,
  input  wire logic [25:0] sample_data,
  input  wire logic        init_active,
  input  wire logic        init_done,
  input  wire logic [9:0]  init_word,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_err,
  input  wire logic [2:0]  cmd_sensor_address_field,
  input  wire logic [2:0]  cmd_function_code_field,
  input  wire logic [9:0]  cmd_error_number,
  output logic             frame_start,
  output logic      [9:0]  frame_data,
  output logic             frame_chain_format,
  output logic             bus_switch_close,
  output logic             sync_pulldown_en
);

  psi5sw_pkg::psi5sw_state_t st;
  psi5sw_pkg::psi5sw_state_t next_st;

  // Rounded, saturated 16-bit word from the 26-bit result
  function automatic logic [15:0] to_word16(input logic [25:0] d);
    logic signed [20:0] t;
    t = $signed({d[25], d[25:6]}) + $signed({20'h00000, d[5]});
    if (t > $signed(21'h007fff))
      to_word16 = 16'h7fff;
    else if (t < $signed(21'h1f8000))
      to_word16 = 16'h8000;
    else
      to_word16 = t[15:0];
  endfunction

  // Clip to plus or minus the second-slot limit
  function automatic logic [15:0] clip_lim(input logic [15:0] v);
    if ($signed(v) > $signed(16'(`PSI5SW_CLIP_LIM)))
      clip_lim = 16'(`PSI5SW_CLIP_LIM);
    else if ($signed(v) < -$signed(16'(`PSI5SW_CLIP_LIM)))
      clip_lim = -16'(`PSI5SW_CLIP_LIM);
    else
      clip_lim = v;
  endfunction

  // One-cycle hit when the slot timer reaches a nonzero slot value
  function automatic logic slot_hit(input logic        a,
                                    input logic [4:0]  p,
                                    input logic [10:0] c,
                                    input logic [9:0]  t);
    slot_hit = a && (p == 5'h00) && (t != 10'h000) && (c == {1'b0, t});
  endfunction

  logic        rise;
  logic        hit_a;
  logic        hit_b;
  logic        hit_setup;
  logic        hit_chain;
  logic        overlap;
  logic        mute;
  logic        offset_now;
  logic [9:0]  chain_slot;
  logic [15:0] fresh;
  logic        ahb_go;
  logic [15:0] clipped;

  assign rise       = st.sync_s2 && !st.sync_d;
  assign offset_now = st.flt_s2[5];
  assign mute       = st.flt_s2[1] || st.flt_s2[0];
  assign fresh      = to_word16(sample_data);
  assign ahb_go     = hsel && htrans[1] && hready;
  assign clipped    = clip_lim(st.sample);

  // Address 1/4, 2/5, 3/6 share chain slots one to three
  always_comb begin
    case (st.addr)
      3'h1, 3'h4: chain_slot = CHAIN_SLOT1;
      3'h2, 3'h5: chain_slot = CHAIN_SLOT2;
      3'h3, 3'h6: chain_slot = CHAIN_SLOT3;
      default:    chain_slot = 10'h000;
    endcase
  end

  assign hit_a     = slot_hit(st.act, st.pre, st.cnt, st.slot_a);
  assign hit_b     = slot_hit(st.act, st.pre, st.cnt, st.slot_b);
  assign hit_setup = slot_hit(st.act, st.pre, st.cnt, SETUP_SLOT);
  assign hit_chain = slot_hit(st.act, st.pre, st.cnt, chain_slot);

  // Frames conflict when the slots lie closer than one frame
  always_comb begin
    if (st.slot_b >= st.slot_a)
      overlap = (11'(st.slot_b) - 11'(st.slot_a)) <
                11'(`PSI5SW_FRAME_UNITS);
    else
      overlap = (11'(st.slot_a) - 11'(st.slot_b)) <
                11'(`PSI5SW_FRAME_UNITS);
  end

  always_comb begin
    next_st    = st;
    next_st.fs = 1'b0;
    next_st.sync_s1 = sync_pin;
    next_st.sync_s2 = st.sync_s1;
    next_st.sync_d  = st.sync_s2;
    next_st.flt_s1  = {offset_err_pin, selftest_fail_pin,
                       identity_valid_flag, identity_default_flag,
                       undervolt_pin, temp_fail_pin};
    next_st.flt_s2  = st.flt_s1;
    if (st.flt_s2[4] || !st.flt_s2[3] || !st.flt_s2[2])
      next_st.defect = 1'b1;

    // Slot timer in 0.5 us units from the sync rising edge
    if (rise) begin
      next_st.pre = 5'h00;
      next_st.cnt = 11'h000;
      next_st.act = 1'b1;
    end else if (st.act) begin
      if (st.pre == 5'(`PSI5SW_UNIT_CYC - 1)) begin
        next_st.pre = 5'h00;
        if (st.cnt == 11'h7ff)
          next_st.act = 1'b0;
        else
          next_st.cnt = st.cnt + 11'h001;
      end else begin
        next_st.pre = st.pre + 5'h01;
      end
    end

    // Sample latch at the edge or the first slot
    if (rise && !st.lat)
      next_st.sample = fresh;
    else if (st.lat && (((st.mode == psi5sw_pkg::PSI5SW_MODE_HIRES) &&
             hit_a) || ((st.mode == psi5sw_pkg::PSI5SW_MODE_CHAIN) &&
             hit_chain)))
      next_st.sample = fresh;

    case (st.mode)
      psi5sw_pkg::PSI5SW_MODE_HIRES: begin
        if (hit_a) begin
          next_st.fs = 1'b1;
          if (init_active)
            next_st.fdata = init_word;
          else if (st.defect || offset_now)
            next_st.fdata = DEFECT_WORD;
          else if (st.lat)
            next_st.fdata = fresh[15:6];
          else
            next_st.fdata = st.sample[15:6];
        end else if (hit_b && !overlap) begin
          next_st.fs = 1'b1;
          if (init_active)
            next_st.fdata = init_word;
          else if (st.defect || offset_now)
            next_st.fdata = DEFECT_WORD;
          else
            next_st.fdata = clipped[9:0];
        end
      end
      psi5sw_pkg::PSI5SW_MODE_CHAIN: begin
        case (st.chain)
          psi5sw_pkg::PSI5SW_CH_INIT: begin
            if (hit_setup && init_active) begin
              next_st.fs    = 1'b1;
              next_st.fdata = init_word;
            end
            if (init_done)
              next_st.chain = psi5sw_pkg::PSI5SW_CH_WADDR;
          end
          psi5sw_pkg::PSI5SW_CH_WADDR,
          psi5sw_pkg::PSI5SW_CH_REPA: begin
            if (hit_setup && (st.rep_cnt != 2'h0)) begin
              next_st.fs      = 1'b1;
              next_st.fdata   = (st.rep_cnt == 2'h2) ? st.rep_code
                                                     : st.rep_word;
              next_st.rep_cnt = st.rep_cnt - 2'h1;
              if ((st.rep_cnt == 2'h1) &&
                  (st.chain == psi5sw_pkg::PSI5SW_CH_REPA)) begin
                next_st.chain = psi5sw_pkg::PSI5SW_CH_BLANK;
                next_st.blank = BLANK_CYC;
              end
            end else if (cmd_valid && (st.rep_cnt == 2'h0) &&
                         (st.chain == psi5sw_pkg::PSI5SW_CH_WADDR) &&
                         (cmd_sensor_address_field ==
                          `PSI5SW_ADDR_NONE)) begin
              next_st.rep_cnt = 2'h2;
              if (cmd_err ||
                  (cmd_function_code_field == `PSI5SW_ADDR_NONE) ||
                  (cmd_function_code_field == `PSI5SW_ADDR_GLOBAL)) begin
                next_st.rep_code = `PSI5SW_RC_ERR;
                next_st.rep_word = cmd_error_number;
              end else begin
                next_st.addr     = cmd_function_code_field;
                next_st.rep_code = `PSI5SW_RC_OK;
                next_st.rep_word = {7'h00, cmd_function_code_field};
                next_st.chain    = psi5sw_pkg::PSI5SW_CH_REPA;
              end
            end
          end
          psi5sw_pkg::PSI5SW_CH_BLANK: begin
            if (st.blank == 24'h000000)
              next_st.chain = psi5sw_pkg::PSI5SW_CH_WRUN;
            else
              next_st.blank = st.blank - 24'h000001;
          end
          psi5sw_pkg::PSI5SW_CH_WRUN: begin
            if (cmd_valid &&
                (cmd_sensor_address_field == `PSI5SW_ADDR_GLOBAL) &&
                (cmd_function_code_field == 3'h0)) begin
              next_st.rep_cnt = 2'h2;
              if (cmd_err) begin
                next_st.rep_code = `PSI5SW_RC_ERR;
                next_st.rep_word = cmd_error_number;
              end else begin
                next_st.rep_code = `PSI5SW_RC_OK;
                next_st.rep_word = `PSI5SW_RUN_WORD;
              end
              next_st.chain = psi5sw_pkg::PSI5SW_CH_REPR;
            end
          end
          psi5sw_pkg::PSI5SW_CH_REPR: begin
            if (hit_chain) begin
              next_st.fs      = 1'b1;
              next_st.fdata   = (st.rep_cnt == 2'h2) ? st.rep_code
                                                     : st.rep_word;
              next_st.rep_cnt = st.rep_cnt - 2'h1;
              if (st.rep_cnt == 2'h1)
                next_st.chain = (st.rep_code == `PSI5SW_RC_OK) ?
                                psi5sw_pkg::PSI5SW_CH_RUN :
                                psi5sw_pkg::PSI5SW_CH_WRUN;
            end
          end
          psi5sw_pkg::PSI5SW_CH_RUN: begin
            if (hit_chain) begin
              next_st.fs    = 1'b1;
              if (st.defect || offset_now)
                next_st.fdata = DEFECT_WORD;
              else if (st.lat)
                next_st.fdata = fresh[15:6];
              else
                next_st.fdata = st.sample[15:6];
            end
          end
          default: next_st.chain = psi5sw_pkg::PSI5SW_CH_INIT;
        endcase
      end
      default: next_st.fs = 1'b0;
    endcase
    if (mute)
      next_st.fs = 1'b0;

    // AHB-Lite slave, zero wait states
    next_st.dph = ahb_go && hwrite;
    if (ahb_go)
      next_st.haddr = haddr[7:0];
    if (ahb_go && !hwrite) begin
      case (haddr[7:0])
        `PSI5SW_OFF_CTRL:  next_st.hrdata = {29'h0, st.lat, st.mode};
        `PSI5SW_OFF_SLOTA: next_st.hrdata = {22'h0, st.slot_a};
        `PSI5SW_OFF_SLOTB: next_st.hrdata = {22'h0, st.slot_b};
        `PSI5SW_OFF_STAT:  next_st.hrdata = {24'h0, st.defect, mute,
                                             st.chain, st.addr};
        `PSI5SW_OFF_WORD:  next_st.hrdata = {16'h0, st.sample};
        default:           next_st.hrdata = 32'h0;
      endcase
    end
    if (st.dph) begin
      case (st.haddr)
        `PSI5SW_OFF_CTRL: begin
          next_st.mode = psi5sw_pkg::psi5sw_mode_t'(
            hwdata[`PSI5SW_CTRL_MODE_LSB +: 2]);
          next_st.lat  = hwdata[`PSI5SW_CTRL_LAT_BIT];
        end
        `PSI5SW_OFF_SLOTA: next_st.slot_a = hwdata[9:0];
        `PSI5SW_OFF_SLOTB: next_st.slot_b = hwdata[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st        <= '0;
      st.mode   <= psi5sw_pkg::psi5sw_mode_t'(`PSI5SW_CTRL_RST);
      st.slot_a <= `PSI5SW_SLOT_RST;
      st.slot_b <= `PSI5SW_SLOT_RST;
      st.chain  <= psi5sw_pkg::PSI5SW_CH_INIT;
      st.flt_s1 <= 6'h0c;
      st.flt_s2 <= 6'h0c;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign hrdata             = st.hrdata;
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign frame_start        = st.fs && ce;
  assign frame_data         = st.fdata;
  assign frame_chain_format = (st.mode == psi5sw_pkg::PSI5SW_MODE_CHAIN);
  assign bus_switch_close   = frame_chain_format && !st.addr[2] &&
                              (st.addr != 3'h0);
  assign sync_pulldown_en   = frame_chain_format &&
                              ((st.chain == psi5sw_pkg::PSI5SW_CH_INIT) ||
                               (st.chain == psi5sw_pkg::PSI5SW_CH_RUN));

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_mute_silent: assert property (
    mute && ce |=> !frame_start) else $error("frame sent while muted");
  a_defect_latch: assert property (
    st.defect |=> st.defect) else $error("defect latch released");
  a_defect_word: assert property (
    ce && hit_a && offset_now && !init_active && !mute &&
    (st.mode == psi5sw_pkg::PSI5SW_MODE_HIRES)
    |=> frame_start && (frame_data == DEFECT_WORD))
    else $error("offset error frame not defect word");
  a_slotb_drop: assert property (
    ce && hit_b && !hit_a && overlap &&
    (st.mode == psi5sw_pkg::PSI5SW_MODE_HIRES) |=> !frame_start)
    else $error("second slot sent despite overlap");
  a_run_addr: assert property (
    (st.chain == psi5sw_pkg::PSI5SW_CH_RUN) |->
    (st.addr != 3'h0) && (st.addr != 3'h7))
    else $error("run mode with invalid address");
  a_switch_map: assert property (
    frame_chain_format && (st.addr inside {3'h4, 3'h5, 3'h6})
    |-> !bus_switch_close) else $error("switch closed for high address");
  a_pulldown_mode: assert property (
    sync_pulldown_en |-> (st.mode == psi5sw_pkg::PSI5SW_MODE_CHAIN))
    else $error("pulldown outside chain mode");
  a_blank_hold: assert property (
    ce && $changed(st.chain) && (st.chain == psi5sw_pkg::PSI5SW_CH_BLANK)
    |=> !frame_start [*4]) else $error("frame during blanking");
  a_hires_hi: assert property (
    ce && hit_a && !st.lat && !init_active && !mute && !offset_now &&
    !st.defect && (st.mode == psi5sw_pkg::PSI5SW_MODE_HIRES)
    |=> frame_data == $past(st.sample[15:6]))
    else $error("first slot data mismatch");

  c_run_reached: cover property (st.chain == psi5sw_pkg::PSI5SW_CH_RUN);
  c_hires_two: cover property (
    (st.mode == psi5sw_pkg::PSI5SW_MODE_HIRES) && hit_b && !overlap);
  c_defect_set: cover property ($rose(st.defect));

endmodule
